//--- bdtx_cfg.svh
// constants of the buffer, diagnostic and tape command executor
`ifndef BDTX_CFG_SVH
`define BDTX_CFG_SVH
// function codes
`define BDTX_FN_BUFIO     8'h0E
`define BDTX_FN_DIAG      8'h0F
`define BDTX_FN_TINIT     8'h10
`define BDTX_FN_REWIND    8'h11
`define BDTX_FN_SPACE     8'h12
`define BDTX_FN_WFM       8'h14
`define BDTX_FN_ERASE     8'h17
// buffer move
`define BDTX_DIR_IN       8'h00
`define BDTX_DIR_OUT      8'hFF
`define BDTX_RAM_LO       16'h4000
`define BDTX_RAM_HI       16'h45FF
`define BDTX_RAM_WORDS    1536
`define BDTX_RAM_END      17'h04600
// modifier fields and self-test constants
`define BDTX_MOD_SUPP     0
`define BDTX_DMOD_FULL    8'h00
`define BDTX_DMOD_ROM     8'h01
`define BDTX_DMOD_CYL0    8'h02
`define BDTX_DIAG_PAT     16'h55AA
`define BDTX_ROM_WORDS    12'hFFF
`define BDTX_ROM_SUM      8'h00
// expansion port map
`define BDTX_EXP_C0_CH0   16'hC070
`define BDTX_EXP_C0_CH1   16'hC0B0
`define BDTX_EXP_C1_CH0   16'hC0D0
`define BDTX_EXP_C1_CH1   16'hC0E0
// status codes
`define BDTX_ST_OK        8'h00
`define BDTX_ST_INVCMD    8'h01
`define BDTX_ST_DIAGERR   8'h02
`define BDTX_ST_BADADDR   8'h03
`define BDTX_ST_OFFDONE   8'h04
`endif

//--- bdtx_pkg.sv
// types of the buffer, diagnostic and tape command executor
package bdtx_pkg;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0000,
      ST_DEC   = 4'b0001,
      ST_MEM   = 4'b0010,
      ST_RAM   = 4'b0011,
      ST_DRV   = 4'b0100,
      ST_DWAIT = 4'b0101,
      ST_ROM   = 4'b0110,
      ST_TAPE  = 4'b0111,
      ST_TWAIT = 4'b1000,
      ST_POST  = 4'b1001
   } bdtx_state_e;
   typedef enum logic [2:0] {
      DOP_RECAL  = 3'b000,
      DOP_SEEK   = 3'b001,
      DOP_READID = 3'b010,
      DOP_WRITE  = 3'b011,
      DOP_READ   = 3'b100
   } bdtx_dop_e;
   typedef enum logic [2:0] {
      TOP_INIT   = 3'b000,
      TOP_REWIND = 3'b001,
      TOP_SPACE  = 3'b010,
      TOP_WFM    = 3'b011,
      TOP_ERASE  = 3'b100
   } bdtx_top_e;
endpackage

//--- bdtx_exec.sv
// command executor for buffer move, drive self-test and tape functions
`timescale 1ns/1ps
`default_nettype none
`include "bdtx_cfg.svh"
module bdtx_exec
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // command from parameter block
   input  wire logic        cmdValid,
   input  wire logic [7:0]  cmdFunc,
   input  wire logic [1:0]  cmdUnit,
   input  wire logic [15:0] cmdModifier,
   input  wire logic [15:0] cmdBoardAddr,
   input  wire logic [7:0]  cmdIoSpec,
   input  wire logic [23:0] cmdBufPtr,
   input  wire logic [15:0] cmdCount,
   output logic             cmdReady_reg,
   // status and interrupt
   input  wire logic        semClear,
   output logic             statusSem_reg,
   output logic [7:0]       statusCode_reg,
   output logic [1:0]       statusUnit_reg,
   output logic             statusLong_reg,
   output logic             intr_reg,
   // system memory
   output logic             memReq_reg,
   output logic             memWe_reg,
   output logic [23:0]      memAddr_reg,
   output logic [7:0]       memWdata_reg,
   input  wire logic        memAck,
   input  wire logic [7:0]  memRdata,
   // disk drive
   input  wire logic [15:0] drvMaxCyl,
   output logic             drvReq_reg,
   output logic [2:0]       drvOp_reg,
   output logic [1:0]       drvUnit_reg,
   output logic [15:0]      drvCyl_reg,
   output logic [3:0]       drvHead_reg,
   output logic [15:0]      drvWdata_reg,
   input  wire logic        drvDone,
   input  wire logic        drvErr,
   input  wire logic [15:0] drvIdCyl,
   input  wire logic [15:0] drvRdata,
   // firmware rom
   output logic [11:0]      romAddr_reg,
   input  wire logic [7:0]  romData,
   // tape module
   output logic             tapeReq_reg,
   output logic [2:0]       tapeOp_reg,
   output logic [1:0]       tapeUnit_reg,
   input  wire logic        tapeAck,
   input  wire logic        tapeErr,
   input  wire logic [3:0]  tapeOffDone,
   input  wire logic        tapeWriteActive,
   output logic             tapeEraseHead_reg,
   // expansion port address lookup
   input  wire logic        expConn,
   input  wire logic        expChan,
   input  wire logic [2:0]  expPort,
   output logic [15:0]      expAddr_reg
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] portAddr(input logic conn, input logic chan, input logic [2:0] port);
      logic [15:0] base;
      base = conn ? (chan ? `BDTX_EXP_C1_CH1 : `BDTX_EXP_C1_CH0)
                  : (chan ? `BDTX_EXP_C0_CH1 : `BDTX_EXP_C0_CH0);
      return base + {12'h000, port, 1'b0};
   endfunction

   function automatic logic [1:0] lowestPend(input logic [3:0] p);
      return p[0] ? 2'h0 : p[1] ? 2'h1 : p[2] ? 2'h2 : 2'h3;
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0]          ram [0:`BDTX_RAM_WORDS-1];
   bdtx_pkg::bdtx_state_e state_reg;
   logic [7:0]          func_reg;
   logic [15:0]         mod_reg;
   logic                dirOut_reg;
   logic [10:0]         ramIdx_reg;
   logic [15:0]         left_reg;
   logic [7:0]          rdByte_reg;
   logic [2:0]          step_reg;
   logic [7:0]          sum_reg;
   logic [3:0]          offBusy_reg;
   logic [3:0]          pend_reg;
   logic                postLong_reg;
   logic [7:0]          postCode_reg;

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire logic       take     = cmdValid && cmdReady_reg;
   wire logic       suppress = mod_reg[`BDTX_MOD_SUPP];
   wire logic [7:0] diagMod  = mod_reg[15:8];
   wire logic       isKnown  = func_reg inside {`BDTX_FN_BUFIO, `BDTX_FN_DIAG, `BDTX_FN_TINIT,
                               `BDTX_FN_REWIND, `BDTX_FN_SPACE, `BDTX_FN_WFM, `BDTX_FN_ERASE};
   wire logic       dirOk    = cmdIoSpec == `BDTX_DIR_IN || cmdIoSpec == `BDTX_DIR_OUT;
   wire logic       addrOk   = cmdBoardAddr >= `BDTX_RAM_LO && cmdBoardAddr <= `BDTX_RAM_HI
                               && ({1'b0, cmdBoardAddr} + {1'b0, cmdCount}) <= `BDTX_RAM_END;
   wire logic       isLongT  = func_reg == `BDTX_FN_REWIND || func_reg == `BDTX_FN_SPACE
                               || func_reg == `BDTX_FN_ERASE;
   wire logic [1:0] pendUnit = lowestPend(pend_reg);
   // an off-line completion waits for an idle executor and a cleared semaphore;
   // it also yields to a command taken in the same cycle, which would otherwise be lost
   wire logic       offPost  = state_reg == bdtx_pkg::ST_IDLE && |pend_reg && !statusSem_reg && !take;
   wire logic       postNow  = state_reg == bdtx_pkg::ST_POST;
   wire logic       romLast  = romAddr_reg == `BDTX_ROM_WORDS;
   wire logic [7:0] romSum   = sum_reg + romData;
   // full test walks recal, seek, id, write, read; cylinder-0 test walks seek, id
   wire logic       diagFull = diagMod == `BDTX_DMOD_FULL;
   wire logic [2:0] diagOp   = diagFull ? step_reg : (step_reg == 3'h0 ? 3'h1 : 3'h2);
   wire logic [2:0] diagEnd  = diagFull ? 3'h4 : 3'h1;
   wire logic       diagBad  = drvErr
                               || (drvOp_reg == bdtx_pkg::DOP_READID && drvIdCyl != drvCyl_reg)
                               || (drvOp_reg == bdtx_pkg::DOP_READ && drvRdata != `BDTX_DIAG_PAT);

   // ------------------------------------------------------------
   // control state machine
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         state_reg    <= bdtx_pkg::ST_IDLE;
         func_reg     <= 8'h00;
         mod_reg      <= 16'h0000;
         dirOut_reg   <= 1'b0;
         ramIdx_reg   <= 11'h000;
         left_reg     <= 16'h0000;
         step_reg     <= 3'h0;
         sum_reg      <= 8'h00;
         postCode_reg <= `BDTX_ST_OK;
         postLong_reg <= 1'b0;
         memReq_reg   <= 1'b0;
         memWe_reg    <= 1'b0;
         memAddr_reg  <= 24'h000000;
         memWdata_reg <= 8'h00;
         drvReq_reg   <= 1'b0;
         drvOp_reg    <= 3'h0;
         drvUnit_reg  <= 2'h0;
         drvCyl_reg   <= 16'h0000;
         drvHead_reg  <= 4'h0;
         drvWdata_reg <= 16'h0000;
         romAddr_reg  <= 12'h000;
         tapeReq_reg  <= 1'b0;
         tapeOp_reg   <= 3'h0;
         tapeUnit_reg <= 2'h0;
      end
      else
      begin
         drvReq_reg  <= 1'b0;
         tapeReq_reg <= 1'b0;
         unique case (state_reg)
            bdtx_pkg::ST_IDLE:
               if (take && !offPost)
               begin
                  func_reg     <= cmdFunc;
                  mod_reg      <= cmdModifier;
                  dirOut_reg   <= cmdIoSpec == `BDTX_DIR_OUT;
                  ramIdx_reg   <= 11'(cmdBoardAddr - `BDTX_RAM_LO);
                  memAddr_reg  <= cmdBufPtr;
                  left_reg     <= cmdCount;
                  drvUnit_reg  <= cmdUnit;
                  tapeUnit_reg <= cmdUnit;
                  postCode_reg <= `BDTX_ST_OK;
                  postLong_reg <= 1'b0;
                  step_reg     <= 3'h0;
                  sum_reg      <= 8'h00;
                  romAddr_reg  <= 12'h000;
                  if (cmdFunc == `BDTX_FN_BUFIO && !(dirOk && addrOk))
                     postCode_reg <= `BDTX_ST_BADADDR;
                  state_reg    <= bdtx_pkg::ST_DEC;
               end
            bdtx_pkg::ST_DEC:
               if (!isKnown)
               begin
                  postCode_reg <= `BDTX_ST_INVCMD;
                  state_reg    <= bdtx_pkg::ST_POST;
               end
               else if (func_reg == `BDTX_FN_BUFIO)
                  state_reg <= (postCode_reg != `BDTX_ST_OK || left_reg == 16'h0000) ? bdtx_pkg::ST_POST
                             : dirOut_reg ? bdtx_pkg::ST_RAM : bdtx_pkg::ST_MEM;
               else if (func_reg == `BDTX_FN_DIAG)
                  state_reg <= diagMod == `BDTX_DMOD_ROM ? bdtx_pkg::ST_ROM
                             : (diagMod == `BDTX_DMOD_FULL || diagMod == `BDTX_DMOD_CYL0) ? bdtx_pkg::ST_DRV
                             : bdtx_pkg::ST_POST;
               else
               begin
                  tapeOp_reg  <= func_reg == `BDTX_FN_TINIT  ? bdtx_pkg::TOP_INIT
                               : func_reg == `BDTX_FN_REWIND ? bdtx_pkg::TOP_REWIND
                               : func_reg == `BDTX_FN_SPACE  ? bdtx_pkg::TOP_SPACE
                               : func_reg == `BDTX_FN_WFM    ? bdtx_pkg::TOP_WFM
                               : bdtx_pkg::TOP_ERASE;
                  tapeReq_reg <= 1'b1;
                  state_reg   <= bdtx_pkg::ST_TWAIT;
               end
            // host memory to board RAM, one byte per acknowledge
            bdtx_pkg::ST_MEM:
            begin
               memReq_reg <= !memAck;
               memWe_reg  <= 1'b0;
               if (memAck)
               begin
                  ram[ramIdx_reg] <= memRdata;
                  ramIdx_reg      <= ramIdx_reg + 11'h001;
                  memAddr_reg     <= memAddr_reg + 24'h000001;
                  left_reg        <= left_reg - 16'h0001;
                  if (left_reg == 16'h0001)
                     state_reg <= bdtx_pkg::ST_POST;
               end
            end
            // board RAM to host memory
            bdtx_pkg::ST_RAM:
            begin
               memReq_reg   <= !memAck;
               memWe_reg    <= 1'b1;
               memWdata_reg <= ram[ramIdx_reg];
               if (memAck)
               begin
                  memReq_reg   <= 1'b0;
                  ramIdx_reg   <= ramIdx_reg + 11'h001;
                  memAddr_reg  <= memAddr_reg + 24'h000001;
                  left_reg     <= left_reg - 16'h0001;
                  if (left_reg == 16'h0001)
                     state_reg <= bdtx_pkg::ST_POST;
               end
            end
            bdtx_pkg::ST_DRV:
            begin
               drvReq_reg   <= 1'b1;
               drvOp_reg    <= diagOp;
               drvHead_reg  <= 4'h0;
               drvCyl_reg   <= diagFull ? drvMaxCyl : 16'h0000;
               drvWdata_reg <= `BDTX_DIAG_PAT;
               state_reg    <= bdtx_pkg::ST_DWAIT;
            end
            bdtx_pkg::ST_DWAIT:
               if (drvDone)
               begin
                  step_reg <= step_reg + 3'h1;
                  if (diagBad)
                  begin
                     postCode_reg <= `BDTX_ST_DIAGERR;
                     state_reg    <= bdtx_pkg::ST_POST;
                  end
                  else
                     state_reg <= step_reg == diagEnd ? bdtx_pkg::ST_POST : bdtx_pkg::ST_DRV;
               end
            // rom byte trails its address by a cycle: skip the first edge, hold the last address
            bdtx_pkg::ST_ROM:
            begin
               step_reg <= {1'b0, romLast, 1'b1};
               if (step_reg[0])
                  sum_reg <= romSum;
               if (!romLast)
                  romAddr_reg <= romAddr_reg + 12'h001;
               if (step_reg[1])
               begin
                  postCode_reg <= romSum == `BDTX_ROM_SUM ? `BDTX_ST_OK : `BDTX_ST_DIAGERR;
                  state_reg    <= bdtx_pkg::ST_POST;
               end
            end
            bdtx_pkg::ST_TWAIT:
               if (tapeAck)
               begin
                  if (tapeErr)
                     postCode_reg <= `BDTX_ST_DIAGERR;
                  state_reg <= bdtx_pkg::ST_POST;
               end
            bdtx_pkg::ST_POST:
               state_reg <= bdtx_pkg::ST_IDLE;
            default:
               state_reg <= bdtx_pkg::ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // off-line tracking, status posting, semaphore
   // ------------------------------------------------------------
   wire logic       offStart = state_reg == bdtx_pkg::ST_TWAIT && tapeAck && !tapeErr && isLongT;
   wire logic [3:0] unitBit  = 4'h1 << tapeUnit_reg;
   wire logic [3:0] pendBit  = offPost ? 4'h1 << pendUnit : 4'h0;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         offBusy_reg       <= 4'h0;
         pend_reg          <= 4'h0;
         statusSem_reg     <= 1'b0;
         statusCode_reg    <= `BDTX_ST_OK;
         statusUnit_reg    <= 2'h0;
         statusLong_reg    <= 1'b0;
         intr_reg          <= 1'b0;
         cmdReady_reg      <= 1'b0;
         tapeEraseHead_reg <= 1'b0;
         expAddr_reg       <= 16'h0000;
      end
      else
      begin
         offBusy_reg <= (offBusy_reg & ~tapeOffDone) | (offStart ? unitBit : 4'h0);
         pend_reg    <= (pend_reg & ~pendBit) | (tapeOffDone & offBusy_reg);
         // new post wins over a clear in the same cycle
         statusSem_reg <= postNow || offPost || (statusSem_reg && !semClear);
         intr_reg      <= offPost || (postNow && !suppress);
         if (offPost)
         begin
            statusCode_reg <= `BDTX_ST_OFFDONE;
            statusUnit_reg <= pendUnit;
            statusLong_reg <= 1'b1;
         end
         else if (postNow)
         begin
            statusCode_reg <= postCode_reg;
            statusUnit_reg <= drvUnit_reg;
            statusLong_reg <= postLong_reg;
         end
         cmdReady_reg      <= state_reg == bdtx_pkg::ST_IDLE && !take && !statusSem_reg && !postNow
                              && pend_reg == 4'h0;
         tapeEraseHead_reg <= tapeWriteActive;
         expAddr_reg       <= portAddr(expConn, expChan, expPort);
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   property p_one_intr;
      @(posedge clk) disable iff (srst) intr_reg |=> !intr_reg;
   endproperty
   a_one_intr: assert property (p_one_intr) else $error("interrupt longer than one cycle");

   property p_intr_sem;
      @(posedge clk) disable iff (srst) intr_reg |-> statusSem_reg;
   endproperty
   a_intr_sem: assert property (p_intr_sem) else $error("interrupt without posted status");

   property p_suppress;
      @(posedge clk) disable iff (srst) (postNow && suppress) |=> !intr_reg;
   endproperty
   a_suppress: assert property (p_suppress) else $error("suppressed interrupt was raised");

   property p_second_intr;
      @(posedge clk) disable iff (srst) offPost |=> intr_reg && statusCode_reg == `BDTX_ST_OFFDONE;
   endproperty
   a_second_intr: assert property (p_second_intr) else $error("off-line completion not signalled");

   property p_wait_sem;
      @(posedge clk) disable iff (srst) (offPost && !postNow) |-> $past(!statusSem_reg || semClear);
   endproperty
   a_wait_sem: assert property (p_wait_sem) else $error("off-line post before semaphore clear");

   property p_pattern;
      @(posedge clk) disable iff (srst)
         (drvReq_reg && drvOp_reg == bdtx_pkg::DOP_WRITE) |-> drvWdata_reg == `BDTX_DIAG_PAT && drvHead_reg == 4'h0;
   endproperty
   a_pattern: assert property (p_pattern) else $error("self-test write has wrong pattern or head");

   property p_cyl0;
      @(posedge clk) disable iff (srst)
         (drvReq_reg && diagMod == `BDTX_DMOD_CYL0) |-> drvCyl_reg == 16'h0000 && drvOp_reg != bdtx_pkg::DOP_WRITE;
   endproperty
   a_cyl0: assert property (p_cyl0) else $error("cylinder-0 test left cylinder 0");

   property p_invalid;
      @(posedge clk) disable iff (srst) (state_reg == bdtx_pkg::ST_DEC && !isKnown) |=> ##1 statusCode_reg == `BDTX_ST_INVCMD;
   endproperty
   a_invalid: assert property (p_invalid) else $error("unknown code not reported");

   property p_dir;
      @(posedge clk) disable iff (srst) memReq_reg |-> memWe_reg == (state_reg == bdtx_pkg::ST_RAM);
   endproperty
   a_dir: assert property (p_dir) else $error("buffer move direction wrong");

   property p_even;
      @(posedge clk) disable iff (srst) !expAddr_reg[0] && expAddr_reg[15:8] == 8'hC0 || expAddr_reg == 16'h0000;
   endproperty
   a_even: assert property (p_even) else $error("expansion port address not even");
endmodule
`default_nettype wire

//--- bdtx_far_model.sv
// far-side responder: host memory, disk drive, firmware rom and tape module
`timescale 1ns/1ps
`default_nettype none
module bdtx_far_model
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // memory
   input  wire logic        memReq_reg,
   input  wire logic [23:0] memAddr_reg,
   output logic             memAck,
   output logic [7:0]       memRdata,
   // drive
   input  wire logic        drvReq_reg,
   input  wire logic [2:0]  drvOp_reg,
   input  wire logic [15:0] drvCyl_reg,
   input  wire logic [15:0] drvWdata_reg,
   output logic             drvDone,
   output logic [15:0]      drvIdCyl,
   output logic [15:0]      drvRdata,
   // rom and tape
   input  wire logic [11:0] romAddr_reg,
   output logic [7:0]       romData,
   input  wire logic        tapeReq_reg,
   output logic             tapeAck
);
   logic drvBusy;
   logic tapeBusy;
   always_ff @(posedge clk)
   begin
      memAck   <= !srst && memReq_reg && !memAck;
      // data is only valid with the ack; otherwise it keeps flipping
      memRdata <= (memReq_reg && !memAck) ? memAddr_reg[7:0] : ~memRdata;
      drvBusy  <= !srst && drvReq_reg;
      drvDone  <= !srst && drvBusy;
      tapeBusy <= !srst && tapeReq_reg;
      tapeAck  <= !srst && tapeBusy;
      // alternating bytes: any 4096 consecutive addresses sum to zero
      romData  <= romAddr_reg[0] ? 8'h01 : 8'hFF;
      if (drvReq_reg && drvOp_reg < 3'h2)
         drvIdCyl <= drvOp_reg[0] ? drvCyl_reg : 16'h0000;
      if (drvReq_reg && drvOp_reg == 3'h3)
         drvRdata <= drvWdata_reg;
   end
endmodule
`default_nettype wire

//--- bdtx_exec_tb.sv
// self-checking bench of the command executor
`timescale 1ns/1ps
`default_nettype none
module bdtx_exec_tb;
   logic clk, srst, cmdValid, semClear, tapeWriteActive, expConn, expChan, cmdReady_reg, statusSem_reg;
   logic statusLong_reg, intr_reg, memReq_reg, memWe_reg, memAck, drvReq_reg, drvDone, tapeReq_reg, tapeAck;
   logic tapeEraseHead_reg, weSeen, drvErr;
   logic [4:0]  lastTape;
   logic [7:0]  lastData;
   logic [1:0]  cmdUnit, statusUnit_reg, drvUnit_reg, tapeUnit_reg;
   logic [2:0]  expPort, drvOp_reg, tapeOp_reg;
   logic [3:0]  tapeOffDone, drvHead_reg;
   logic [7:0]  cmdFunc, cmdIoSpec, statusCode_reg, memWdata_reg, memRdata, romData;
   logic [11:0] romAddr_reg;
   logic [15:0] cmdModifier, cmdBoardAddr, cmdCount, drvCyl_reg, drvWdata_reg, drvIdCyl, drvRdata, expAddr_reg, seekCyl;
   logic [23:0] memAddr_reg, lastAddr;
   logic [15:0] base [4] = '{16'hC070, 16'hC0B0, 16'hC0D0, 16'hC0E0};
   wire logic        tapeErr   = 1'b0;
   wire logic [15:0] drvMaxCyl = 16'h0133;
   wire logic [23:0] cmdBufPtr = 24'h01234E;
   int failures, checks, cyc, intrCnt;
   bdtx_exec dut_u (.clk, .srst, .cmdValid, .cmdFunc, .cmdUnit, .cmdModifier, .cmdBoardAddr, .cmdIoSpec,
      .cmdBufPtr, .cmdCount, .cmdReady_reg, .semClear, .statusSem_reg, .statusCode_reg, .statusUnit_reg,
      .statusLong_reg, .intr_reg, .memReq_reg, .memWe_reg, .memAddr_reg, .memWdata_reg, .memAck, .memRdata,
      .drvMaxCyl, .drvReq_reg, .drvOp_reg, .drvUnit_reg, .drvCyl_reg, .drvHead_reg, .drvWdata_reg, .drvDone,
      .drvErr, .drvIdCyl, .drvRdata, .romAddr_reg, .romData, .tapeReq_reg, .tapeOp_reg, .tapeUnit_reg, .tapeAck,
      .tapeErr, .tapeOffDone, .tapeWriteActive, .tapeEraseHead_reg, .expConn, .expChan, .expPort, .expAddr_reg);
   bdtx_far_model far_u (.clk, .srst, .memReq_reg, .memAddr_reg, .memAck, .memRdata, .drvReq_reg, .drvOp_reg,
      .drvCyl_reg, .drvWdata_reg, .drvDone, .drvIdCyl, .drvRdata, .romAddr_reg, .romData, .tapeReq_reg, .tapeAck);
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ------------------------------------------------
   // monitors and hang guard
   // ------------------------------------------------
   always @(posedge clk)
   begin
      cyc++;
      if (intr_reg === 1'b1)
         intrCnt++;
      if (memReq_reg === 1'b1)
         {weSeen, lastAddr, lastData} = {memWe_reg, memAddr_reg, memWdata_reg};
      if (tapeReq_reg === 1'b1)
         lastTape = {tapeUnit_reg, tapeOp_reg};
      if (drvReq_reg === 1'b1 && drvOp_reg === 3'h1)
         seekCyl = drvCyl_reg;
      if (cyc == 30000)
      begin
         failures++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic issue(input logic [7:0] fn, input logic [15:0] md, input logic [1:0] un,
                        input logic [15:0] ba, input logic [7:0] sp, input logic [15:0] cnt);
      for (int i = 0; i < 50 && cmdReady_reg !== 1'b1; i++)
         @(negedge clk);
      {cmdFunc, cmdModifier, cmdUnit, cmdBoardAddr, cmdIoSpec, cmdCount} = {fn, md, un, ba, sp, cnt};
      cmdValid = 1'b1;
      @(negedge clk);
      cmdValid = 1'b0;
   endtask
   // status word is {long flag, code}; interrupts counted since the last clear
   task automatic wait_post(input logic [15:0] st, input int nIntr);
      for (int i = 0; i < 9000 && statusSem_reg !== 1'b1; i++)
         @(negedge clk);
      // let the interrupt pulse reach the counter
      @(negedge clk);
      chk("status", st, {7'h00, statusLong_reg, statusCode_reg});
      chk("interrupts", nIntr[15:0], intrCnt[15:0]);
      intrCnt = 0;
      semClear = 1'b1;
      @(negedge clk);
      semClear = 1'b0;
   endtask
   // ------------------------------------------------
   // test sequence
   // ------------------------------------------------
   initial
   begin
      {cmdValid, semClear, tapeWriteActive, expConn, expChan, expPort, tapeOffDone, drvErr} = '0;
      {cmdFunc, cmdModifier, cmdUnit, cmdBoardAddr, cmdIoSpec, cmdCount} = '0;
      srst = 1'b1;
      repeat (6) @(negedge clk);
      srst = 1'b0;
      issue(8'h05, 16'h0000, 2'h0, 16'h0000, 8'h00, 16'h0000);
      wait_post(16'h0001, 1);
      for (int d = 0; d < 2; d++)
      begin
         issue(8'h0E, 16'h0000, 2'h0, 16'h4000 + 16'(d), d ? 8'hFF : 8'h00, 16'h0003 - 16'(d));
         wait_post(16'h0000, 1);
         chk("write enable", 16'(d), {15'h0, weSeen});
         chk("last address", 16'h2350 - 16'(d), lastAddr[15:0]);
      end
      chk("read-out data", 16'h0050, {8'h00, lastData});
      issue(8'h0E, 16'h0000, 2'h0, 16'h45FF, 8'h00, 16'h0002);
      wait_post(16'h0003, 1);
      issue(8'h0F, 16'h0000, 2'h1, 16'h0000, 8'h00, 16'h0000);
      wait_post(16'h0000, 1);
      chk("seek cylinder", 16'h0133, seekCyl);
      issue(8'h0F, 16'h0200, 2'h1, 16'h0000, 8'h00, 16'h0000);
      wait_post(16'h0000, 1);
      chk("seek cylinder", 16'h0000, seekCyl);
      drvErr = 1'b1;
      issue(8'h0F, 16'h0200, 2'h1, 16'h0000, 8'h00, 16'h0000);
      wait_post(16'h0002, 1);
      drvErr = 1'b0;
      issue(8'h0F, 16'h0300, 2'h1, 16'h0000, 8'h00, 16'h0000);
      wait_post(16'h0000, 1);
      issue(8'h10, 16'h0000, 2'h0, 16'h0000, 8'h00, 16'h0000);
      wait_post(16'h0000, 1);
      repeat (2)
      begin
         issue(8'h14, 16'h0001, 2'h0, 16'h0000, 8'h00, 16'h0000);
         wait_post(16'h0000, 0);
         chk("tape op", 16'h0003, {11'h000, lastTape});
      end
      for (int u = 0; u < 3; u++)
      begin
         issue(u == 0 ? 8'h11 : u == 1 ? 8'h12 : 8'h17, 16'(u & 1), 2'(u), 16'h0000, 8'h00, 16'h0000);
         wait_post(16'h0000, (u & 1) ? 0 : 1);
         chk("tape op", {11'h000, 2'(u), u == 2 ? 3'h4 : 3'(u + 1)}, {11'h000, lastTape});
         tapeOffDone = 4'h1 << u;
         @(negedge clk);
         tapeOffDone = 4'h0;
         wait_post(16'h0104, 1);
         chk("unit", 16'(u), {14'h0, statusUnit_reg});
      end
      issue(8'h11, 16'h0000, 2'h3, 16'h0000, 8'h00, 16'h0000);
      wait_post(16'h0000, 1);
      issue(8'h0F, 16'h0100, 2'h0, 16'h0000, 8'h00, 16'h0000);
      repeat (20) @(negedge clk);
      tapeOffDone = 4'h8;
      @(negedge clk);
      tapeOffDone = 4'h0;
      wait_post(16'h0000, 1);
      wait_post(16'h0104, 1);
      for (int k = 0; k < 32; k++)
      begin
         {expConn, expChan, expPort} = 5'(k);
         @(negedge clk);
         chk("port address", base[k >> 3] + 16'(2 * (k & 7)), expAddr_reg);
      end
      tapeWriteActive = 1'b1;
      @(negedge clk);
      chk("erase head", 16'h0001, {15'h0, tapeEraseHead_reg});
      tapeWriteActive = 1'b0;
      @(negedge clk);
      chk("erase head", 16'h0000, {15'h0, tapeEraseHead_reg});
      end_of_test();
   end
endmodule
`default_nettype wire
